// ---- global_config_register_bank.sv ----
// Global control and status register bank on an Avalon-MM slave
//
// Summary of operation
// R1: Writing reset register starts one-microsecond chip reset
// R2: Read-only identification byte, low nibble is revision
// R3: Copy bit broadcasts per-channel writes to all
// R4: Style field picks open-drain or push-pull polarity
// R5: Channel-mask bit suppresses every per-channel interrupt
// R6: One-second timer raises masked-by-default interrupt
// R7: Six-bit code selects observed receiver or transmitter
// R8: Software avoids reserved observation codes
// R9: Aux pin direction bit, one is input
// R10: Aux value drives output or reports input
// R11: E-rate clock pin released when disabled
// R12: E-rate select picks frame rate or 2.048 MHz
// R13: T-rate clock pin released when disabled
// R14: Sixteen-bit error count as two bytes
// R15: Channel-0 jitter peaks as split byte pairs
// R16: Jitter meter halt, kind and bandwidth bits
// R17: Reserved bits read zero, writes ignored
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module global_config_register_bank
  import glob_cfg_pkg::*;
#(
  parameter int CHANNELS = 17,
  parameter logic [3:0] REVISION = 4'h0,
  // Arbitrary family nibble of the identification byte
  parameter logic [3:0] FAMILY = 4'ha,
  parameter int SECOND_CYCLES = int'(SECOND_CYCLES_DEF)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic soft_reset_active,
  input wire logic chan_wr_req,
  input wire logic [4:0] chan_wr_sel,
  output logic [CHANNELS-1:0] chan_wr_en,
  input wire logic [CHANNELS-1:0] chan_irq_status,
  output logic irq,
  output logic irq_pin_out,
  output logic irq_pin_oe,
  output logic observe_enable,
  output logic observe_is_tx,
  output logic [4:0] observe_channel,
  input wire logic [1:0] aux_pin_in,
  output logic [1:0] aux_pin_out,
  output logic [1:0] aux_pin_oe,
  output logic e_rate_clock_out,
  output logic e_rate_clock_oe,
  output logic t_rate_clock_out,
  output logic t_rate_clock_oe,
  input wire logic [15:0] error_count_value,
  input wire logic [11:0] positive_jitter_peak,
  input wire logic [11:0] negative_jitter_peak,
  output logic jitter_meter_halt,
  output logic jitter_meter_kind,
  output logic jitter_meter_bandwidth
);

  initial begin
    if (CHANNELS < 2 || CHANNELS > 32) begin
      $error("CHANNELS must lie between 2 and 32");
    end
    if (SECOND_CYCLES < 2) begin
      $error("SECOND_CYCLES must be at least 2");
    end
  end

  // Observation code: valid flag, transmitter flag, channel number
  function automatic logic [6:0] decode_observe(input logic [5:0] code);
    logic [6:0] res;
    res = 7'h00;
    if (code[4:0] != 5'h00 && (code[5] || code[4:0] <= 5'h10)) begin
      res = {1'b1, code[5], code[4:0]};
    end
    return res;
  endfunction : decode_observe

  localparam int TICK_W = $clog2(SECOND_CYCLES);
  localparam int SRST_W = $clog2(SOFT_RESET_CYCLES + 1);

  logic ack;
  logic [SRST_W-1:0] srst_cnt;
  logic [TICK_W-1:0] tick_cnt;
  logic [7:0] settings;
  logic [7:0] observe;
  logic [7:0] aux_pin;
  logic [7:0] ref_clock;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] jit_cfg;
  logic [7:0] rd_byte;
  logic [31:0] e_acc;
  logic [31:0] t_acc;

  wire [10:0] index = avs_address[ADDR_W-1:2];
  wire request = avs_read | avs_write;
  wire busy = srst_cnt != '0;
  wire taken = request & ack;
  wire wr_take = taken & avs_write & avs_byteenable[0];
  wire [7:0] wdata = avs_writedata[7:0];

  wire hit_revision = index == IDX_REVISION;
  wire hit_err_low = index == IDX_ERR_LOW;
  wire hit_err_high = index == IDX_ERR_HIGH;
  wire hit_soft_reset = index == IDX_SOFT_RESET;
  wire hit_settings = index == IDX_SETTINGS;
  wire hit_observe = index == IDX_OBSERVE;
  wire hit_aux = index == IDX_AUX_PIN;
  wire hit_ref = index == IDX_REF_CLOCK;
  wire hit_status = index == IDX_IRQ_STATUS;
  wire hit_mask = index == IDX_IRQ_MASK;
  wire hit_jit_cfg = index == IDX_JIT_CFG;
  wire hit_pos_low = index == IDX_JIT_POS_LOW;
  wire hit_pos_high = index == IDX_JIT_POS_HIGH;
  wire hit_neg_low = index == IDX_JIT_NEG_LOW;
  wire hit_neg_high = index == IDX_JIT_NEG_HIGH;

  // Bus: one wait cycle per access; a soft reset stalls the bus
  assign avs_waitrequest = request & (~ack | busy);
  wire next_ack = request & ~ack & ~busy;

  // Any value written to byte lane 0 of the reset register triggers it
  wire srst_start = wr_take & hit_soft_reset; // see R1
  assign soft_reset_active = busy;

  // Aux pin readback: inputs report the pin, outputs the stored level
  wire [1:0] aux_way = aux_pin[AUX_WAY0+1:AUX_WAY0];
  wire [1:0] aux_store = aux_pin[AUX_VALUE0+1:AUX_VALUE0];
  wire [1:0] aux_seen = (aux_way & aux_pin_in) | (~aux_way & aux_store);

  // Read views; reserved bits are tied to zero here as well as in storage
  wire [7:0] rd_id = {FAMILY, REVISION}; // see R2
  wire [7:0] rd_settings = {3'b000, settings[4:0]}; // see R17
  wire [7:0] rd_observe = {2'b00, observe[5:0]};
  wire [7:0] rd_aux = {4'h0, aux_seen, aux_way}; // see R10
  wire [7:0] rd_ref = {4'h0, ref_clock[3:0]};
  wire [7:0] rd_status = {6'h00, irq_status[1:0]};
  wire [7:0] rd_mask = {6'h00, irq_mask[1:0]};
  wire [7:0] rd_jit_cfg = {5'h00, jit_cfg[2:0]}; // see R16
  wire [7:0] rd_pos_high = {4'h0, positive_jitter_peak[11:8]}; // see R15
  wire [7:0] rd_neg_high = {4'h0, negative_jitter_peak[11:8]}; // see R15

  // Unmapped addresses read as zero
  assign rd_byte =
    hit_revision ? rd_id : // see R2
    hit_err_low ? error_count_value[7:0] : // see R14
    hit_err_high ? error_count_value[15:8] : // see R14
    hit_settings ? rd_settings : // see R17
    hit_observe ? rd_observe :
    hit_aux ? rd_aux : // see R10
    hit_ref ? rd_ref :
    hit_status ? rd_status :
    hit_mask ? rd_mask :
    hit_jit_cfg ? rd_jit_cfg : // see R16
    hit_pos_low ? positive_jitter_peak[7:0] : // see R15
    hit_pos_high ? rd_pos_high : // see R15
    hit_neg_low ? negative_jitter_peak[7:0] : // see R15
    hit_neg_high ? rd_neg_high : // see R15
    8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  // Captured once per access, so the value stands while the master looks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (next_ack) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // Soft reset counter; finishes within one microsecond
  wire [SRST_W-1:0] next_srst_cnt =
    srst_start ? SRST_W'(SOFT_RESET_CYCLES) :
    busy ? srst_cnt - SRST_W'(1) : srst_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_cnt <= '0;
    end else begin
      srst_cnt <= next_srst_cnt; // see R1
    end
  end

  // Writable registers; one short process each, implemented bits only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settings <= SETTINGS_RST;
    end else if (busy) begin
      settings <= SETTINGS_RST; // see R1
    end else if (wr_take && hit_settings) begin
      settings <= {3'b000, wdata[4:0]}; // see R17
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      observe <= OBSERVE_RST;
    end else if (busy) begin
      observe <= OBSERVE_RST; // see R1
    end else if (wr_take && hit_observe) begin
      observe <= {2'b00, wdata[5:0]}; // see R7
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_pin <= AUX_PIN_RST;
    end else if (busy) begin
      aux_pin <= AUX_PIN_RST; // see R1
    end else if (wr_take && hit_aux) begin
      aux_pin <= {4'h0, wdata[3:0]}; // see R9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_clock <= REF_CLOCK_RST;
    end else if (busy) begin
      ref_clock <= REF_CLOCK_RST; // see R1
    end else if (wr_take && hit_ref) begin
      ref_clock <= {4'h0, wdata[3:0]}; // see R11
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (busy) begin
      irq_mask <= IRQ_MASK_RST; // see R1
    end else if (wr_take && hit_mask) begin
      irq_mask <= {6'h00, wdata[1:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jit_cfg <= JIT_CFG_RST;
    end else if (busy) begin
      jit_cfg <= JIT_CFG_RST; // see R1
    end else if (wr_take && hit_jit_cfg) begin
      jit_cfg <= {5'h00, wdata[2:0]}; // see R16
    end
  end

  assign jitter_meter_bandwidth = jit_cfg[0]; // see R16
  assign jitter_meter_kind = jit_cfg[1];
  assign jitter_meter_halt = jit_cfg[2];

  // Per-channel write fan-out; the copy bit widens it to all channels
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_fanout
      assign chan_wr_en[ch] = chan_wr_req &
        (settings[SET_COPY] || chan_wr_sel == 5'(ch)); // see R3
    end
  endgenerate

  // Observation select; channel zero and receiver codes above 16 decode to nothing
  wire [6:0] obs = decode_observe(observe[5:0]); // see R7
  assign observe_enable = obs[6];
  assign observe_is_tx = obs[5];
  assign observe_channel = obs[4:0];

  // Aux pins: way 1 is input, so the driver is released
  genvar pin;
  generate
    for (pin = 0; pin < 2; pin++) begin : g_aux
      assign aux_pin_oe[pin] = ~aux_way[pin]; // see R9
      assign aux_pin_out[pin] = aux_store[pin]; // see R10
    end
  endgenerate

  // One-second timer runs from the master clock
  wire tick = tick_cnt == TICK_W'(SECOND_CYCLES - 1);
  wire [TICK_W-1:0] next_tick_cnt = tick ? '0 : tick_cnt + TICK_W'(1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt; // see R6
    end
  end

  // Events: the set beats a same-cycle write-one clear
  wire chan_event = |chan_irq_status & ~settings[SET_CHAN_MASK]; // see R5
  wire tick_event = tick & ~settings[SET_TICK_MASK]; // see R6
  wire [7:0] clear = (wr_take && hit_status) ? wdata : 8'h00;
  wire [7:0] events = {6'h00, chan_event, tick_event};
  wire [7:0] next_irq_status = (irq_status & ~clear) | events;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 8'h00;
    end else if (busy) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  wire [1:0] irq_live = irq_status[1:0] & ~irq_mask[1:0];
  assign irq = |irq_live;

  // Pin style: X0 open drain low, 01 push-pull low, 11 push-pull high
  wire [1:0] style = settings[SET_PIN_STYLE+1:SET_PIN_STYLE];
  wire style_push_pull = style[0];
  wire style_active_high = style[1];
  assign irq_pin_oe = style_push_pull | irq; // see R4
  assign irq_pin_out =
    style_push_pull ? ~(style_active_high ^ irq) : 1'b0; // see R4

  // Step of a reference accumulator; the frame rate is the slow pick
  function automatic logic [31:0] rate_step(input logic fast_sel,
                                            input logic [31:0] fast_inc);
    return fast_sel ? fast_inc : INC_FRAME;
  endfunction : rate_step

  // Phase accumulators approximate the rate from 250 MHz; truncated steps run slightly slow
  wire [31:0] e_inc = rate_step(ref_clock[REF_E_SEL], INC_E_RATE);
  wire [31:0] t_inc = rate_step(ref_clock[REF_T_SEL], INC_T_RATE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e_acc <= '0;
    end else begin
      e_acc <= e_acc + e_inc; // see R12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_acc <= '0;
    end else begin
      t_acc <= t_acc + t_inc; // see R13
    end
  end

  // Edges jitter by one 4 ns period; fine for a reference output
  assign e_rate_clock_out = e_acc[31];
  assign t_rate_clock_out = t_acc[31];
  assign e_rate_clock_oe = ref_clock[REF_E_EN]; // see R11
  assign t_rate_clock_oe = ref_clock[REF_T_EN]; // see R13

endmodule : global_config_register_bank

// ---- glob_cfg_pkg.sv ----
// Constants for the global control and status register bank
package glob_cfg_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [10:0] IDX_REVISION = 11'h000;
  localparam logic [10:0] IDX_ERR_LOW = 11'h023;
  localparam logic [10:0] IDX_ERR_HIGH = 11'h024;
  localparam logic [10:0] IDX_SOFT_RESET = 11'h040;
  localparam logic [10:0] IDX_SETTINGS = 11'h041;
  localparam logic [10:0] IDX_OBSERVE = 11'h042;
  localparam logic [10:0] IDX_AUX_PIN = 11'h043;
  localparam logic [10:0] IDX_REF_CLOCK = 11'h044;
  localparam logic [10:0] IDX_IRQ_STATUS = 11'h045;
  localparam logic [10:0] IDX_IRQ_MASK = 11'h046;
  localparam logic [10:0] IDX_JIT_CFG = 11'h7e5;
  localparam logic [10:0] IDX_JIT_POS_LOW = 11'h7e6;
  localparam logic [10:0] IDX_JIT_POS_HIGH = 11'h7e7;
  localparam logic [10:0] IDX_JIT_NEG_LOW = 11'h7e8;
  localparam logic [10:0] IDX_JIT_NEG_HIGH = 11'h7e9;
  // Field positions
  localparam int SET_TICK_MASK = 0;
  localparam int SET_CHAN_MASK = 1;
  localparam int SET_PIN_STYLE = 2;
  localparam int SET_COPY = 4;
  localparam int AUX_WAY0 = 0;
  localparam int AUX_VALUE0 = 2;
  localparam int REF_T_SEL = 0;
  localparam int REF_T_EN = 1;
  localparam int REF_E_SEL = 2;
  localparam int REF_E_EN = 3;
  localparam int IRQ_TICK = 0;
  localparam int IRQ_CHAN = 1;
  // Reset values
  localparam logic [7:0] SETTINGS_RST = 8'h01;
  localparam logic [7:0] OBSERVE_RST = 8'h00;
  localparam logic [7:0] AUX_PIN_RST = 8'h0f;
  localparam logic [7:0] REF_CLOCK_RST = 8'h0f;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] JIT_CFG_RST = 8'h00;
  // Timing
  localparam longint CLK_HZ = 250_000_000;
  localparam longint SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYCLES = int'((SOFT_RESET_NS * CLK_HZ) / 1e9);
  localparam longint SECOND_CYCLES_DEF = CLK_HZ;
  localparam longint FRAME_HZ = 8000;
  localparam longint E_RATE_HZ = 2_048_000;
  localparam longint T_RATE_HZ = 1_544_000;
  localparam logic [31:0] INC_FRAME = 32'((FRAME_HZ << 32) / CLK_HZ);
  localparam logic [31:0] INC_E_RATE = 32'((E_RATE_HZ << 32) / CLK_HZ);
  localparam logic [31:0] INC_T_RATE = 32'((T_RATE_HZ << 32) / CLK_HZ);
endpackage : glob_cfg_pkg

// ---- glob_cfg_chk.sv ----
// Port checker for the global register bank
`timescale 1ns/1ps
module glob_cfg_chk
  import glob_cfg_pkg::*;
#(parameter int CHANNELS = 17) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic soft_reset_active,
  input wire logic chan_wr_req,
  input wire logic [4:0] chan_wr_sel,
  input wire logic [CHANNELS-1:0] chan_wr_en,
  input wire logic irq,
  input wire logic irq_pin_oe,
  input wire logic observe_enable,
  input wire logic [4:0] observe_channel
);
  // Counts active cycles so the exact reset length is visible at its end
  logic [8:0] sr_len;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sr_len <= '0;
    else sr_len <= soft_reset_active ? sr_len + 9'd1 : 9'd0;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_reset_len: assert property (
    $fell(soft_reset_active) |-> sr_len == 9'(SOFT_RESET_CYCLES))
    else $error("soft reset length wrong");
  chk_reset_start: assert property (
    avs_write && !avs_waitrequest && avs_address[12:2] == IDX_SOFT_RESET
    |=> soft_reset_active) else $error("soft reset not started");
  chk_reset_wait: assert property (
    soft_reset_active && (avs_read || avs_write) |-> avs_waitrequest)
    else $error("bus answered during soft reset");
  chk_upper_zero: assert property (
    avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  chk_fanout_own: assert property (
    chan_wr_req && chan_wr_sel < CHANNELS |-> chan_wr_en[chan_wr_sel])
    else $error("own channel not written");
  chk_fanout_idle: assert property (
    !chan_wr_req |-> chan_wr_en == '0) else $error("write enable without request");
  chk_irq_pin: assert property (
    irq |-> irq_pin_oe) else $error("interrupt pin not driven");
  chk_observe_range: assert property (
    observe_enable |-> observe_channel inside {[5'd1:5'd16]})
    else $error("observed channel out of range");
  cov_soft_reset: cover property ($rose(soft_reset_active));
  cov_broadcast: cover property (chan_wr_req && (&chan_wr_en));
  cov_irq: cover property ($rose(irq));
endmodule : glob_cfg_chk

// ---- global_config_register_bank_tb_top.sv ----
// Self-checking bench for the global register bank
`timescale 1ns/1ps
module global_config_register_bank_tb_top;
  import glob_cfg_pkg::*;
  localparam int CHANNELS = 17;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, soft_reset_active;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, q, r;
  logic [3:0] avs_byteenable;
  logic chan_wr_req, irq, irq_pin_out, irq_pin_oe, observe_enable;
  logic observe_is_tx, e_rate_clock_out, e_rate_clock_oe;
  logic t_rate_clock_out, t_rate_clock_oe;
  logic [4:0] chan_wr_sel, observe_channel;
  logic [16:0] chan_wr_en, chan_irq_status;
  logic [1:0] aux_pin_in, aux_pin_out, aux_pin_oe;
  logic [15:0] error_count_value;
  logic [11:0] positive_jitter_peak, negative_jitter_peak;
  logic jitter_meter_halt, jitter_meter_kind, jitter_meter_bandwidth;
  logic [7:0] d;
  int err_count, tests_run;
  int ne, nt;
  logic pe, pt;
  logic [10:0] rw_idx [5] = '{IDX_SETTINGS, IDX_OBSERVE, IDX_REF_CLOCK,
                             IDX_JIT_CFG, IDX_IRQ_MASK};
  logic [7:0] rw_msk [5] = '{8'h1f, 8'h3f, 8'h0f, 8'h07, 8'h03};
  // Identification nibbles are arbitrary
  global_config_register_bank #(.REVISION(4'h3), .FAMILY(4'h5),
    .SECOND_CYCLES(100)) uut (.*);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [10:0] idx, input logic [7:0] v);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= 32'(v);
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [10:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    cmp(q, 32'(e));
  endtask : rdc
  task automatic styles(input logic v);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, IDX_SETTINGS, 8'(s << 2) | 8'h01);
      @(negedge clk);
      cmp({irq_pin_oe, irq_pin_out}, {s[0] | v, s[0] & (s[1] ? v : !v)});
    end
  endtask : styles
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200_000;
    err_count++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, chan_wr_req} = 3'b000;
    {avs_address, avs_writedata, chan_wr_sel, chan_irq_status} = '0;
    avs_byteenable = 4'hf;
    aux_pin_in = 2'b11;
    {error_count_value, positive_jitter_peak, negative_jitter_peak} = '0;
    err_count = 0;
    tests_run = 0;
    r = $urandom(32'h0000_e1cc);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdc(IDX_SETTINGS, SETTINGS_RST);
    rdc(IDX_AUX_PIN, 8'h0f);
    rdc(IDX_REF_CLOCK, 8'h0f);
    rdc(IDX_OBSERVE, 8'h00);
    rdc(11'h100, 8'h00);
    cmp({e_rate_clock_oe, t_rate_clock_oe, aux_pin_oe}, 4'hc);
    // 5 us at 2.048 MHz and 1.544 MHz gives 10.24 and 7.72 periods
    ne = 0;
    nt = 0;
    pe = e_rate_clock_out;
    pt = t_rate_clock_out;
    for (int c = 0; c < 1250; c++) begin
      @(negedge clk);
      ne += int'(e_rate_clock_out && !pe);
      nt += int'(t_rate_clock_out && !pt);
      pe = e_rate_clock_out;
      pt = t_rate_clock_out;
    end
    cmp(ne inside {[10:11]}, 1'b1);
    cmp(nt inside {[7:8]}, 1'b1);
    bus(1'b1, IDX_REVISION, 8'hff);
    rdc(IDX_REVISION, 8'h53);
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 6; k++) begin
        d = 8'($urandom);
        // Observe codes stay legal; reserved ones are software's fault
        if (i == 1) d = 8'($urandom_range(0, 16)) | (d & 8'h20);
        bus(1'b1, rw_idx[i], d);
        rdc(rw_idx[i], d & rw_msk[i]);
        @(negedge clk);
        if (i == 1) cmp(observe_enable, d[4:0] != 5'h00);
        if (i == 1 && d[4:0] != 5'h00) cmp({observe_is_tx, observe_channel}, d[5:0]);
        if (i == 2) cmp({e_rate_clock_oe, t_rate_clock_oe}, {d[3], d[1]});
        if (i == 3) cmp({jitter_meter_halt, jitter_meter_kind,
          jitter_meter_bandwidth}, d[2:0]);
      end
    end
    @(posedge clk);
    r = $urandom;
    error_count_value <= r[15:0];
    positive_jitter_peak <= r[27:16];
    negative_jitter_peak <= r[31:20];
    rdc(IDX_ERR_LOW, r[7:0]);
    rdc(IDX_ERR_HIGH, r[15:8]);
    rdc(IDX_JIT_POS_LOW, r[23:16]);
    rdc(IDX_JIT_POS_HIGH, {4'h0, r[27:24]});
    rdc(IDX_JIT_NEG_LOW, r[27:20]);
    rdc(IDX_JIT_NEG_HIGH, {4'h0, r[31:28]});
    aux_pin_in <= r[1:0];
    bus(1'b1, IDX_AUX_PIN, 8'h04);
    rdc(IDX_AUX_PIN, 8'h04);
    cmp({aux_pin_oe, aux_pin_out}, 4'hd);
    bus(1'b1, IDX_AUX_PIN, 8'h03);
    rdc(IDX_AUX_PIN, {4'h0, r[1:0], 2'b11});
    cmp(aux_pin_oe, 2'b00);
    bus(1'b1, IDX_SETTINGS, 8'h01);
    d = 8'($urandom_range(0, 16));
    chan_wr_req <= 1'b1;
    chan_wr_sel <= d[4:0];
    @(negedge clk);
    cmp(chan_wr_en, 17'h1 << d);
    bus(1'b1, IDX_SETTINGS, 8'h11);
    @(negedge clk);
    cmp(chan_wr_en, 17'h1_ffff);
    bus(1'b1, IDX_SETTINGS, 8'h01);
    chan_wr_req <= 1'b0;
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    bus(1'b1, IDX_IRQ_STATUS, 8'h03);
    chan_irq_status <= 17'h1 << d;
    rdc(IDX_IRQ_STATUS, 8'h02);
    styles(1'b1);
    bus(1'b1, IDX_IRQ_MASK, 8'h02);
    @(negedge clk);
    cmp(irq, 1'b0);
    styles(1'b0);
    bus(1'b1, IDX_SETTINGS, 8'h03);
    bus(1'b1, IDX_IRQ_STATUS, 8'h02);
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    rdc(IDX_IRQ_STATUS, 8'h00);
    cmp(irq, 1'b0);
    bus(1'b1, IDX_SETTINGS, 8'h02);
    repeat (110) @(posedge clk);
    rdc(IDX_IRQ_STATUS, 8'h01);
    cmp(irq, 1'b1);
    chan_irq_status <= '0;
    bus(1'b1, IDX_SETTINGS, 8'h1f);
    bus(1'b1, IDX_SOFT_RESET, 8'h5a);
    rdc(IDX_SETTINGS, SETTINGS_RST);
    rdc(IDX_IRQ_STATUS, 8'h00);
    end_of_test();
  end
endmodule : global_config_register_bank_tb_top
bind global_config_register_bank glob_cfg_chk #(.CHANNELS(CHANNELS)) chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .soft_reset_active(soft_reset_active),
  .chan_wr_req(chan_wr_req), .chan_wr_sel(chan_wr_sel),
  .chan_wr_en(chan_wr_en), .irq(irq), .irq_pin_oe(irq_pin_oe),
  .observe_enable(observe_enable), .observe_channel(observe_channel));
